// ===== verilog/sbc_channel_ctrl.sv
`timescale 1ns/1ps
// Contract
// - code low bits: 0.8V plus 25mV steps
// - strap decodes sixteen voltages, two limits
// - idle while no channel requests service
// - charge to peak, dump to zero current
// - interleave service among requesting channels
// - skip channels not requesting service
// - channel enters ultra-low-power on light load
// - ultra-low-power target raised 2.5 percent
// - soft-start ramps target at limited slew
// - per-channel two-bit peak current select
// - per-channel five-bit sequence control
// - discharge enable held per channel
// - discharge on when enabled and channel off
// - enabled discharge on in undervoltage above POR
// - below POR all discharge paths open
module sbc_channel_ctrl
    import sbc_pkg::*;
#(
    parameter int N = sbc_pkg::NUM_CH
) (
    input  wire logic                                    SYS_CLK,
    input  wire logic                                    RESET_N,
    input  wire logic                                    STRAP_MODE,
    input  wire logic [N-1:0][sbc_pkg::STRAP_W-1:0]      STRAP_RESISTOR_INPUTS,
    input  wire logic                                    CFG_WR,
    input  wire logic [1:0]                              CFG_CH,
    input  wire logic [sbc_pkg::CODE_W-1:0]              CHANNEL_TARGET_CODE,
    input  wire logic [sbc_pkg::PEAK_CURRENT_SELECT_W-1:0]              PEAK_CURRENT_SELECT,
    input  wire logic [sbc_pkg::SEQ_W-1:0]               SEQUENCE_CONTROL,
    input  wire logic                                    DISCHARGE_ENABLE,
    input  wire logic [N-1:0]                            CH_ENABLE,
    input  wire logic [N-1:0]                            SERVICE_REQ,
    input  wire logic [N-1:0]                            LIGHT_LOAD,
    input  wire logic                                    PEAK_DETECT,
    input  wire logic                                    ZERO_CURRENT_INDICATION,
    input  wire logic                                    VIN_UVLO,
    input  wire logic                                    VIN_POR,
    output logic                                         CHARGE_ON,
    output logic      [N-1:0]                            DUMP_ON,
    output logic      [N-1:0][sbc_pkg::MV_W-1:0]         TARGET_MV,
    output logic      [N-1:0][sbc_pkg::PEAK_CURRENT_SELECT_W-1:0]       PEAK_LIMIT,
    output logic      [N-1:0][sbc_pkg::SEQ_W-1:0]        SEQ_OUT,
    output logic      [N-1:0]                            ULTRA_LOW_POWER_STATE,
    output logic      [N-1:0]                            DISCHARGE_ON,
    output logic      [sbc_pkg::CODE_W-1:0]              CODE_READ
);
    import sbc_pkg::*;

    // three-stage synchroniser for pin inputs
    typedef struct packed
    {
        logic [2:0][N-1:0]  req;      // service request stages
        logic [2:0][N-1:0]  light;    // light-load stages
        logic [2:0]         peak;     // peak detect stages
        logic [2:0]         zx;       // zero-current stages
        logic [N-1:0]       req_q;    // accepted request
        logic [N-1:0]       light_q;  // accepted light load
        logic               peak_q;   // accepted peak
        logic               zx_q;     // accepted zero current
    } sbc_sync_s;

    typedef struct packed
    {
        sbc_sync_s                      sy;        // synchronised inputs
        sbc_state_e                     state;     // servicing state
        logic [1:0]                     cur;       // channel in service
        logic [1:0]                     last;      // last channel served
        logic                           charge;    // charge switch drive
        logic [N-1:0]                   dump;      // dump switch drives
        logic [N-1:0][PEAK_CURRENT_SELECT_W-1:0]       peak_current_select;      // peak current select
        logic [N-1:0][SEQ_W-1:0]        seq;       // sequence control
        logic [N-1:0]                   dis_en;    // discharge enable
        logic [N-1:0]                   dis;       // discharge drive
        logic [N-1:0]                   ulp;       // ultra-low-power state
        logic [N-1:0][MV_W-1:0]         ramp;      // soft-start target
        logic [N-1:0][MV_W-1:0]         tgt;       // regulation target
        logic [SS_CNT_W-1:0]            ss_cnt;    // slew prescaler
        logic [1:0]                     rd_ch;     // mirror read pointer
    } sbc_state_s;

    sbc_state_s st;
    sbc_state_s next_st;
    logic [CODE_W-1:0] mem_rd;
    logic [1:0]        mem_addr;

    // round-robin pick after the last served channel, none if no request
    function automatic logic [2:0] sbc_pick(input logic [N-1:0] req, input logic [1:0] last);
        logic [2:0] res;
        int         k;
        int         c;
        res = 3'b000;
        for (k = N; k >= 1; k--)
        begin
            c = (int'(last) + k) % N;
            if (req[c])
                res = {1'b1, 2'(c)};
        end
        sbc_pick = res;
    endfunction

    // code store sweeps through channels so every target stays fresh
    assign mem_addr = st.rd_ch;

    sbc_cfg_mem #(
        .DEPTH (N),
        .WIDTH (CODE_W)
    ) u_mem (
        .clk     (SYS_CLK),
        .reset_n (RESET_N),
        .wr_en   (CFG_WR),
        .wr_addr (CFG_CH),
        .wr_data (CHANNEL_TARGET_CODE),
        .rd_addr (mem_addr),
        .rd_data (mem_rd)
    );

    // next-state logic for the whole block
    always_comb
    begin
        logic [2:0]        pick;
        logic [1:0]        rch;
        logic [1:0]        prev;
        logic [MV_W-1:0]   base;
        logic [MV_W-1:0]   goal;
        logic              ss_tick;
        pick    = '0;
        rch     = '0;
        prev    = '0;
        base    = '0;
        goal    = '0;
        ss_tick = 1'b0;
        next_st = st;

        // only the second and third stages are compared
        next_st.sy.req   = {st.sy.req[1:0], SERVICE_REQ};
        next_st.sy.light = {st.sy.light[1:0], LIGHT_LOAD};
        next_st.sy.peak  = {st.sy.peak[1:0], PEAK_DETECT};
        next_st.sy.zx    = {st.sy.zx[1:0], ZERO_CURRENT_INDICATION};
        for (int i = 0; i < N; i++)
        begin
            if (st.sy.req[1][i] == st.sy.req[2][i])
                next_st.sy.req_q[i] = st.sy.req[2][i];
            if (st.sy.light[1][i] == st.sy.light[2][i])
                next_st.sy.light_q[i] = st.sy.light[2][i];
        end
        if (st.sy.peak[1] == st.sy.peak[2])
            next_st.sy.peak_q = st.sy.peak[2];
        if (st.sy.zx[1] == st.sy.zx[2])
            next_st.sy.zx_q = st.sy.zx[2];

        // host writes per-channel configuration in one transaction
        if (CFG_WR && int'(CFG_CH) < N)
        begin
            next_st.peak_current_select[CFG_CH]   = PEAK_CURRENT_SELECT;
            next_st.seq[CFG_CH]    = SEQUENCE_CONTROL;
            next_st.dis_en[CFG_CH] = DISCHARGE_ENABLE;
        end

        // soft-start prescaler: one step per microsecond
        if (int'(st.ss_cnt) >= SS_CYCLES - 1)
        begin
            next_st.ss_cnt = '0;
            ss_tick        = 1'b1;
        end
        else
            next_st.ss_cnt = st.ss_cnt + 1'b1;

        // sweep the code store one channel per cycle
        rch = (int'(st.rd_ch) >= N - 1) ? 2'b00 : st.rd_ch + 1'b1;
        next_st.rd_ch = rch;
        // the read register lags the pointer by one cycle, so its data
        // belong to the channel before the one the pointer names now
        prev = (st.rd_ch == 2'b00) ? 2'(N - 1) : st.rd_ch - 1'b1;

        for (int i = 0; i < N; i++)
        begin
            // light load drops channel into low power
            next_st.ulp[i] = st.sy.light_q[i] && CH_ENABLE[i];

            if (STRAP_MODE)
            begin
                base = sbc_strap_mv(STRAP_RESISTOR_INPUTS[i][STRAP_V_W-1:0]);
                next_st.peak_current_select[i] = STRAP_RESISTOR_INPUTS[i][STRAP_HI_BIT] ? 2'b01 : 2'b00;
            end
            else
                base = st.tgt[i];

            // read data only holds full written bytes
            if (!STRAP_MODE && int'(prev) == i)
                next_st.tgt[i] = sbc_code_mv(mem_rd);
            else if (STRAP_MODE)
                next_st.tgt[i] = base;

            goal = base;
            if (st.ulp[i])
                goal = base + MV_W'((32'(base) * ULP_PERMILLE) / PERMILLE_DIV);

            // target slews up to goal, drops to a lower goal at once, restarts from zero when off
            if (!CH_ENABLE[i])
                next_st.ramp[i] = '0;
            else if (ss_tick && st.ramp[i] < goal)
                next_st.ramp[i] = st.ramp[i] + SS_STEP_MV;
            else if (st.ramp[i] > goal)
                next_st.ramp[i] = goal;

            // no discharge drive below power-on reset
            if (!VIN_POR)
                next_st.dis[i] = 1'b0;
            else if (VIN_UVLO)
                next_st.dis[i] = st.dis_en[i];
            else
                next_st.dis[i] = st.dis_en[i] && !CH_ENABLE[i];
        end

        // servicing state machine
        // masked requests never win arbitration
        pick = sbc_pick(st.sy.req_q & CH_ENABLE, st.last);
        case (st.state)
            SBC_IDLE:
            begin
                next_st.charge = 1'b0;
                next_st.dump   = '0;
                if (pick[2])
                begin
                    next_st.cur    = pick[1:0];
                    next_st.charge = 1'b1;
                    next_st.state  = SBC_CHARGE;
                end
            end
            SBC_CHARGE:
            begin
                if (st.sy.peak_q)
                begin
                    next_st.charge        = 1'b0;
                    next_st.dump          = '0;
                    next_st.dump[st.cur]  = 1'b1;
                    next_st.state         = SBC_DUMP;
                end
            end
            SBC_DUMP:
            begin
                // route to output until zero current
                if (st.sy.zx_q)
                begin
                    next_st.dump  = '0;
                    next_st.last  = st.cur;
                    next_st.state = SBC_IDLE;
                end
            end
            default:
            begin
                next_st.state  = SBC_IDLE;
                next_st.charge = 1'b0;
                next_st.dump   = '0;
            end
        endcase
    end

    // synchronous reset: everything off, round robin starts at channel 0
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            st       <= '0;
            st.state <= SBC_IDLE;
            st.last  <= 2'(N - 1);
            st.peak_current_select  <= '{default: PEAK_CURRENT_SELECT_RST};
            st.seq   <= '{default: SEQ_RST};
        end
        else
            st <= next_st;
    end

    // outputs straight from state flops
    assign CHARGE_ON             = st.charge;
    assign DUMP_ON               = st.dump;
    assign TARGET_MV             = st.ramp;
    assign PEAK_LIMIT            = st.peak_current_select;
    assign SEQ_OUT               = st.seq;
    assign ULTRA_LOW_POWER_STATE = st.ulp;
    assign DISCHARGE_ON          = st.dis;
    assign CODE_READ             = mem_rd;
endmodule

// ===== verilog/sbc_pkg.sv
package sbc_pkg;
    // number of regulated channels
    localparam int NUM_CH = 3;
    // output voltages in millivolts
    localparam int BASE_MV = 800;
    localparam int STEP_MV = 25;
    localparam int OFFSET_MV = 1200;
    // ultra-low-power bias, in tenths of a percent
    localparam int ULP_PERMILLE = 25;
    localparam int PERMILLE_DIV = 1000;
    // target code layout
    localparam int CODE_W = 8;
    localparam int CODE_OFS_BIT = 7;
    localparam int CODE_LOW_W = 7;
    localparam int MV_W = 13;
    // peak current limits, milliamps
    localparam int PEAK_CURRENT_SELECT_LO_MA = 600;
    localparam int PEAK_CURRENT_SELECT_HI_MA = 1100;
    // strap decode field widths
    localparam int STRAP_W = 5;
    localparam int STRAP_HI_BIT = 4;
    localparam int STRAP_V_W = 4;
    // per-channel configuration widths
    localparam int PEAK_CURRENT_SELECT_W = 2;
    localparam int SEQ_W = 5;
    // soft-start: one millivolt step per microsecond
    localparam int SS_STEP_US = 1;
    localparam int SYS_CLK_MHZ = 40;
    localparam int SS_CYCLES = SS_STEP_US * SYS_CLK_MHZ;
    localparam int SS_CNT_W = 6;
    localparam logic [MV_W-1:0] SS_STEP_MV = 13'h0001;
    // reset values
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
    localparam logic [PEAK_CURRENT_SELECT_W-1:0] PEAK_CURRENT_SELECT_RST = 2'h0;
    localparam logic [SEQ_W-1:0] SEQ_RST = 5'h00;
    // servicing state machine
    typedef enum logic [1:0]
    {
        SBC_IDLE   = 2'b00,
        SBC_CHARGE = 2'b01,
        SBC_DUMP   = 2'b10
    } sbc_state_e;
    // strap table: sixteen voltages in millivolts
    function automatic logic [MV_W-1:0] sbc_strap_mv(input logic [STRAP_V_W-1:0] idx);
        case (idx)
            4'h0:    sbc_strap_mv = 13'd800;
            4'h1:    sbc_strap_mv = 13'd900;
            4'h2:    sbc_strap_mv = 13'd1000;
            4'h3:    sbc_strap_mv = 13'd1100;
            4'h4:    sbc_strap_mv = 13'd1200;
            4'h5:    sbc_strap_mv = 13'd1350;
            4'h6:    sbc_strap_mv = 13'd1500;
            4'h7:    sbc_strap_mv = 13'd1800;
            4'h8:    sbc_strap_mv = 13'd2200;
            4'h9:    sbc_strap_mv = 13'd2500;
            4'ha:    sbc_strap_mv = 13'd2800;
            4'hb:    sbc_strap_mv = 13'd3000;
            4'hc:    sbc_strap_mv = 13'd3300;
            4'hd:    sbc_strap_mv = 13'd3600;
            4'he:    sbc_strap_mv = 13'd4100;
            default: sbc_strap_mv = 13'd4600;
        endcase
    endfunction
    // register code to millivolts
    function automatic logic [MV_W-1:0] sbc_code_mv(input logic [CODE_W-1:0] code);
        logic [MV_W-1:0] mv;
        mv = MV_W'(BASE_MV) + MV_W'(code[CODE_LOW_W-1:0]) * MV_W'(STEP_MV);
        if (code[CODE_OFS_BIT])
            mv = mv + MV_W'(OFFSET_MV);
        sbc_code_mv = mv;
    endfunction
endpackage

// ===== verilog/sbc_cfg_mem.sv
`timescale 1ns/1ps
// per-channel target code store, registered read
module sbc_cfg_mem #(
    parameter int DEPTH = 3,
    parameter int WIDTH = 8
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // stored codes
        logic [WIDTH-1:0]            rd;    // read register
    } sbc_mem_s;

    sbc_mem_s st;
    sbc_mem_s next_st;

    // write port and registered read
    always_comb
    begin
        next_st = st;
        // an index past the last channel is dropped, never aliased
        if (wr_en && int'(wr_addr) < DEPTH)
            next_st.mem[wr_addr] = wr_data;
        next_st.rd = st.mem[rd_addr];
    end

    // synchronous reset clears all codes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign rd_data = st.rd;
endmodule

// ===== verification/sbc_channel_ctrl_asserts.sv
`timescale 1ns/1ps
// watches switch drives, configured fields and discharge at the controller ports
module sbc_channel_ctrl_chk
#(
    parameter int N = 3
) (
    input wire logic                                  SYS_CLK,
    input wire logic                                  RESET_N,
    input wire logic                                  STRAP_MODE,
    input wire logic [N-1:0][sbc_pkg::STRAP_W-1:0]    STRAP_RESISTOR_INPUTS,
    input wire logic                                  CFG_WR,
    input wire logic [1:0]                            CFG_CH,
    input wire logic [sbc_pkg::PEAK_CURRENT_SELECT_W-1:0]            PEAK_CURRENT_SELECT,
    input wire logic [N-1:0]                          CH_ENABLE,
    input wire logic [N-1:0]                          SERVICE_REQ,
    input wire logic                                  PEAK_DETECT,
    input wire logic                                  ZERO_CURRENT_INDICATION,
    input wire logic                                  VIN_UVLO,
    input wire logic                                  VIN_POR,
    input wire logic                                  CHARGE_ON,
    input wire logic [N-1:0]                          DUMP_ON,
    input wire logic [N-1:0][sbc_pkg::MV_W-1:0]       TARGET_MV,
    input wire logic [N-1:0][sbc_pkg::PEAK_CURRENT_SELECT_W-1:0]     PEAK_LIMIT,
    input wire logic [N-1:0]                          DISCHARGE_ON
);
    import sbc_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // no request for five cycles, so the synchronisers are surely clear
    sequence s_quiet; (SERVICE_REQ == '0)[*5] ##0 (!CHARGE_ON && DUMP_ON == '0); endsequence
    // the inductor goes from charge straight to one output
    sequence s_handoff; !CHARGE_ON && $onehot(DUMP_ON); endsequence
    property p_idle; s_quiet |=> !CHARGE_ON; endproperty
    a_idle: assert property (p_idle) else $error("charge with no request");
    property p_excl; $onehot0(DUMP_ON) && !(CHARGE_ON && DUMP_ON != '0); endproperty
    a_excl: assert property (p_excl) else $error("switches overlap");
    property p_handoff; $fell(CHARGE_ON) |-> s_handoff; endproperty
    a_handoff: assert property (p_handoff) else $error("charge not handed to output");
    // sync, accept and switch flops put the sense input four and five edges back
    property p_peak; $fell(CHARGE_ON) |-> $past(PEAK_DETECT, 4) && $past(PEAK_DETECT, 5); endproperty
    a_peak: assert property (p_peak) else $error("charge ended without peak");
    property p_zero;
        $fell(|DUMP_ON) |-> $past(ZERO_CURRENT_INDICATION, 4) && $past(ZERO_CURRENT_INDICATION, 5);
    endproperty
    a_zero: assert property (p_zero) else $error("dump ended without zero current");
    property p_lim;
        CFG_WR && !STRAP_MODE && CFG_CH < N |=> PEAK_LIMIT[$past(CFG_CH)] == $past(PEAK_CURRENT_SELECT);
    endproperty
    a_lim: assert property (p_lim) else $error("limit field not stored");
    property p_strap;
        (STRAP_MODE && $stable(STRAP_RESISTOR_INPUTS))[*3] |->
            PEAK_LIMIT[0] == {1'b0, STRAP_RESISTOR_INPUTS[0][4]};
    endproperty
    a_strap: assert property (p_strap) else $error("strap limit wrong");
    property p_por; !VIN_POR |=> DISCHARGE_ON == '0; endproperty
    a_por: assert property (p_por) else $error("discharge below reset level");
    property p_dis_on; VIN_POR && !VIN_UVLO |=> (DISCHARGE_ON & $past(CH_ENABLE)) == '0; endproperty
    a_dis_on: assert property (p_dis_on) else $error("discharge on a live channel");
    // target climbs one millivolt at a time, then rests
    property p_slew;
        TARGET_MV[0] > $past(TARGET_MV[0]) |-> TARGET_MV[0] == $past(TARGET_MV[0]) + 13'h0001
            ##1 (TARGET_MV[0] <= $past(TARGET_MV[0]))[*8];
    endproperty
    a_slew: assert property (p_slew) else $error("target stepped too fast");
endmodule

bind sbc_channel_ctrl sbc_channel_ctrl_chk #(.N(N)) i_sbc_channel_ctrl_chk
(
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .STRAP_MODE(STRAP_MODE),
    .STRAP_RESISTOR_INPUTS(STRAP_RESISTOR_INPUTS), .CFG_WR(CFG_WR), .CFG_CH(CFG_CH),
    .PEAK_CURRENT_SELECT(PEAK_CURRENT_SELECT), .CH_ENABLE(CH_ENABLE), .SERVICE_REQ(SERVICE_REQ),
    .PEAK_DETECT(PEAK_DETECT), .ZERO_CURRENT_INDICATION(ZERO_CURRENT_INDICATION),
    .VIN_UVLO(VIN_UVLO), .VIN_POR(VIN_POR), .CHARGE_ON(CHARGE_ON), .DUMP_ON(DUMP_ON),
    .TARGET_MV(TARGET_MV), .PEAK_LIMIT(PEAK_LIMIT), .DISCHARGE_ON(DISCHARGE_ON)
);

// ===== verification/sbc_host_model.sv
`timescale 1ns/1ps
// host side: hands over one whole received byte set per call
module sbc_host_model
(
    input  wire logic                         clk,
    output logic                              wr,
    output logic [1:0]                        ch,
    output logic [sbc_pkg::CODE_W-1:0]        code,
    output logic [sbc_pkg::PEAK_CURRENT_SELECT_W-1:0]        peak_current_select,
    output logic [sbc_pkg::SEQ_W-1:0]         seq,
    output logic                              den
);
    import sbc_pkg::*;
    initial
    begin
        wr = 1'b0;
        ch = 2'h3;
    end
    // host leads every write, device never stalls it
    task automatic put(input logic [1:0] c, input logic [7:0] v, input logic [1:0] l,
                       input logic [4:0] s, input logic d);
        @(posedge clk);
        wr <= 1'b1;
        ch <= c;
        code <= v;
        peak_current_select <= l;
        seq <= s;
        den <= d;
        @(posedge clk);
        wr <= 1'b0;
        // stale data inverted so a late sample never looks right
        code <= ~v;
        peak_current_select <= ~l;
        seq <= ~s;
        den <= ~d;
    endtask
endmodule

// ===== verification/test_simo_buck_boost_channel_control.sv
`timescale 1ns/1ps
// bench plays the host, the current sensors and the supply monitors
module test_simo_buck_boost_channel_control;
    import sbc_pkg::*;
    logic                          clk = 1'b0;
    logic                          rst_n = 1'b0;
    logic                          strap_mode = 1'b0;
    logic [NUM_CH-1:0][STRAP_W-1:0] strap = '0;
    logic [NUM_CH-1:0]             ch_en = 3'h7;
    logic [NUM_CH-1:0]             req = 3'h0;
    logic [NUM_CH-1:0]             light = 3'h0;
    logic                          peak = 1'b0;
    logic                          zero = 1'b0;
    logic                          uvlo = 1'b0;
    logic                          por = 1'b1;
    logic                          wr, den, charge;
    logic [1:0]                    cch, peak_current_select;
    logic [CODE_W-1:0]             code;
    logic [CODE_W-1:0]             crd;
    logic [SEQ_W-1:0]              seq;
    logic [NUM_CH-1:0]             dump, ulp, dis;
    logic [NUM_CH-1:0][MV_W-1:0]   tgt;
    logic [NUM_CH-1:0][PEAK_CURRENT_SELECT_W-1:0] plim;
    logic [NUM_CH-1:0][SEQ_W-1:0]  seqo;
    logic [31:0]                   lfsr = 32'h2b41_e470;
    int                            n_errors = 0;
    int                            num_checks = 0;
    int                            e_lim [3] = '{0, 0, 0};
    int                            e_seq [3] = '{0, 0, 0};
    logic [7:0]                    codes [4] = '{8'h00, 8'h04, 8'h02, 8'h7f};
    int                            rr = 2;
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    sbc_host_model i_sbc_host_model (.clk(clk), .wr(wr), .ch(cch), .code(code), .peak_current_select(peak_current_select),
        .seq(seq), .den(den));
    sbc_channel_ctrl #(.N(NUM_CH)) i_sbc_channel_ctrl (
        .SYS_CLK(clk), .RESET_N(rst_n), .STRAP_MODE(strap_mode),
        .STRAP_RESISTOR_INPUTS(strap), .CFG_WR(wr), .CFG_CH(cch),
        .CHANNEL_TARGET_CODE(code), .PEAK_CURRENT_SELECT(peak_current_select), .SEQUENCE_CONTROL(seq),
        .DISCHARGE_ENABLE(den), .CH_ENABLE(ch_en), .SERVICE_REQ(req), .LIGHT_LOAD(light),
        .PEAK_DETECT(peak), .ZERO_CURRENT_INDICATION(zero), .VIN_UVLO(uvlo), .VIN_POR(por),
        .CHARGE_ON(charge), .DUMP_ON(dump), .TARGET_MV(tgt), .PEAK_LIMIT(plim),
        .SEQ_OUT(seqo), .ULTRA_LOW_POWER_STATE(ulp), .DISCHARGE_ON(dis), .CODE_READ(crd));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // reference voltage for a register code, in millivolts
    function automatic int code_mv(input int c);
        code_mv = 800 + (c % 128) * 25 + (c / 128) * 1200;
    endfunction
    // round robin from the last served channel among requesters
    function automatic int rr_next(input int last, input logic [2:0] r);
        rr_next = last;
        for (int k = 3; k >= 1; k--)
            if (r[(last + k) % 3])
                rr_next = (last + k) % 3;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic hit(input int w);
        case (w)
            0: hit = charge === 1'b1;
            1: hit = (|dump) === 1'b1;
            default: hit = dump === 3'h0;
        endcase
    endfunction
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_for(input int w);
        for (int k = 0; k < 100 && !hit(w); k++)
            cyc(1);
        if (!hit(w))
        begin
            n_errors++;
            end_of_test();
        end
    endtask
    // one write with random limit and sequence fields, then compare all channels
    task automatic cfg(input int c, input logic [7:0] v);
        lfsr = nxt(lfsr);
        i_sbc_host_model.put(2'(c), v, lfsr[1:0], lfsr[6:2], c != 1);
        cyc(1);
        if (c < 3)
        begin
            e_lim[c] = lfsr[1:0];
            e_seq[c] = lfsr[6:2];
        end
        for (int k = 0; k < 3; k++)
        begin
            check(16'(plim[k]), 16'(e_lim[k]));
            check(16'(seqo[k]), 16'(e_seq[k]));
        end
    endtask
    // one service event: peak sensed, then zero current; returns dump pattern
    task automatic svc(input logic [2:0] r_next, output logic [2:0] d);
        wait_for(0);
        @(posedge clk);
        req <= r_next;
        peak <= 1'b1;
        wait_for(1);
        d = dump;
        check(16'(charge), 16'h0000);
        @(posedge clk);
        peak <= 1'b0;
        zero <= 1'b1;
        wait_for(2);
        @(posedge clk);
        zero <= 1'b0;
    endtask
    initial
    begin
        logic [2:0] d;
        cyc(8);
        @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 4; c++)
            cfg(c, codes[c]);
        $display("config fields done");
        // soft start climbs from zero at 40 cycles per millivolt
        cyc(36400);
        for (int c = 0; c < 3; c++)
            check(16'(tgt[c]), 16'(code_mv(codes[c])));
        // read mirror sweeps channels in order; lock on channel 0 first
        for (int k = 0; k < 3 && crd !== codes[0]; k++)
            cyc(1);
        for (int c = 0; c < 3; c++)
        begin
            check(16'(crd), 16'(codes[c]));
            cyc(1);
        end
        @(posedge clk);
        light <= 3'h2;
        cyc(960);
        check(16'(ulp), 16'h0002);
        check(16'(tgt[1]), 16'(900 + 900 * 25 / 1000));
        cfg(1, 8'h00);
        cyc(10);
        check(16'(tgt[1]), 16'(800 + 800 * 25 / 1000));
        cfg(0, 8'h80);
        cyc(400);
        check(16'(tgt[0] > 13'd807 && tgt[0] < 13'd812), 16'h0001);
        $display("targets done");
        @(posedge clk);
        light <= 3'h0;
        strap <= {5'h01, 5'h00, 5'h10};
        strap_mode <= 1'b1;
        cyc(2200);
        for (int c = 0; c < 3; c++)
        begin
            check(16'(tgt[c]), 16'(c == 2 ? 900 : 800));
            check(16'(plim[c]), 16'(c == 0));
        end
        check(16'(ulp), 16'h0000);
        $display("strap done");
        @(posedge clk);
        req <= 3'h5;
        for (int n = 0; n < 4; n++)
        begin
            rr = rr_next(rr, 3'h5);
            svc(n == 3 ? 3'h0 : 3'h5, d);
            check(16'(d), 16'(1 << rr));
        end
        cyc(20);
        check(16'(charge), 16'h0000);
        check(16'(dump), 16'h0000);
        $display("service done");
        for (int k = 0; k < 32; k++)
        begin
            @(posedge clk);
            ch_en <= 3'(k);
            uvlo <= k[3];
            por <= k[4];
            cyc(3);
            check(16'(dis), 16'(k[4] ? (k[3] ? 3'h5 : 3'h5 & ~3'(k)) : 3'h0));
        end
        $display("discharge done");
        end_of_test();
    end
endmodule
